// ===== driver_pkg.sv
// shared constants for the serial-in latched output driver
package driver_pkg;

	// =========================================================
	// widths
	localparam int WORD_WIDTH = 8;
	localparam int CNT_WIDTH = 4;

	// =========================================================
	// reset values
	localparam logic SR_RST_VAL = 1'b0;
	localparam logic LATCH_RST_VAL = 1'b0;
	localparam logic DRIVE_RST_VAL = 1'b0;
	localparam logic SYNC_RST_VAL = 1'b0;

	// =========================================================
	// timing
	localparam int CLK_PERIOD_NS = 40;
	// quiet time the shift word must show before the core trusts it
	localparam int SETTLE_NS = 75;
	localparam int SETTLE_CYC_INT = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [CNT_WIDTH-1:0] SETTLE_CYC = CNT_WIDTH'(SETTLE_CYC_INT);

endpackage

// ===== shift_word_if.sv
// shift register word and shift toggle passed from the link domain to the core
`timescale 1ns/10ps
interface shift_word_if #(
	parameter int WIDTH = 8
);
	logic [WIDTH-1:0] word;
	logic shift_tog;

	modport link (
		output word,
		output shift_tog
	);
	modport core (
		input word,
		input shift_tog
	);
endinterface

// ===== level_sync.sv
// two flip-flop synchroniser for a single level
`timescale 1ns/10ps
module level_sync
	import driver_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// level in and out
	input wire logic level_in,
	output logic level_out
);

	logic meta_q;
	logic sync_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= SYNC_RST_VAL;
			sync_q <= SYNC_RST_VAL;
		end else begin
			meta_q <= level_in;
			sync_q <= meta_q;
		end
	end

	assign level_out = sync_q;

endmodule

// ===== word_settle_sync.sv
// brings the shift word into the core domain once it has stopped moving
`timescale 1ns/10ps
module word_settle_sync
	import driver_pkg::*;
#(
	parameter int WIDTH = WORD_WIDTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// from link domain
	shift_word_if.core src,
	// settled word
	output logic [WIDTH-1:0] word_out
);

	logic tog_meta_q;
	logic tog_sync_q;
	logic tog_prev_q;
	logic [WIDTH-1:0] word_meta_q;
	logic [WIDTH-1:0] word_sync_q;
	logic [WIDTH-1:0] word_prev_q;
	logic [CNT_WIDTH-1:0] quiet_cnt_q;
	logic [WIDTH-1:0] word_out_q;
	logic quiet;

	// =========================================================
	// synchronisers: first stages feed only the second stages
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tog_meta_q <= SYNC_RST_VAL;
			tog_sync_q <= SYNC_RST_VAL;
			tog_prev_q <= SYNC_RST_VAL;
		end else begin
			tog_meta_q <= src.shift_tog;
			tog_sync_q <= tog_meta_q;
			tog_prev_q <= tog_sync_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			word_meta_q <= {WIDTH{SR_RST_VAL}};
			word_sync_q <= {WIDTH{SR_RST_VAL}};
			word_prev_q <= {WIDTH{SR_RST_VAL}};
		end else begin
			word_meta_q <= src.word;
			word_sync_q <= word_meta_q;
			word_prev_q <= word_sync_q;
		end
	end

	// =========================================================
	// settle check
	// bits may be caught skewed while shifting; a word is only taken after it
	// and the shift toggle have stayed put, so fast continuous shifting simply
	// holds the last settled word until the link pauses
	assign quiet = (tog_sync_q == tog_prev_q) && (word_sync_q == word_prev_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			quiet_cnt_q <= '0;
		end else if (!quiet) begin
			quiet_cnt_q <= '0;
		end else if (quiet_cnt_q != SETTLE_CYC) begin
			quiet_cnt_q <= quiet_cnt_q + CNT_WIDTH'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			word_out_q <= {WIDTH{SR_RST_VAL}};
		end else if (quiet && quiet_cnt_q == SETTLE_CYC) begin
			word_out_q <= word_prev_q;
		end
	end

	assign word_out = word_out_q;

endmodule

// ===== serial_latched_driver.sv
// serial-in, latched parallel-out driver logic
//
// Overview of operation
// - rising link clock captures serial input
// - each later edge shifts toward output
// - strobe high copies stages into latches
// - latches follow stages while strobe high
// - blank high turns all drivers off
// - blanking leaves latches and shifter untouched
// - blank low, drivers follow latches
// - serial output is last stage, chainable
`timescale 1ns/10ps
module serial_latched_driver
	import driver_pkg::*;
#(
	parameter int WIDTH = WORD_WIDTH
) (
	// core clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// serial link from the host
	input wire logic shift_clk,
	input wire logic serial_in,
	output logic serial_out,
	// control pins
	input wire logic latch_strobe,
	input wire logic out_blank,
	// output drivers, high = sinking
	output logic [WIDTH-1:0] drive_on
);

	logic link_rst_meta_q;
	logic link_rst_q;
	logic [WIDTH-1:0] shift_q;
	logic [WIDTH-1:0] shift_d;
	logic shift_tog_q;
	logic [WIDTH-1:0] settled_word;
	logic strobe_s;
	logic blank_s;
	logic [WIDTH-1:0] latch_q;
	logic [WIDTH-1:0] drive_q;

	shift_word_if #(.WIDTH(WIDTH)) xfer ();

	// =========================================================
	// link domain reset: asserted at once, released on shift_clk
	always_ff @(posedge shift_clk or posedge sys_rst) begin
		if (sys_rst) begin
			link_rst_meta_q <= 1'b1;
			link_rst_q <= 1'b1;
		end else begin
			link_rst_meta_q <= 1'b0;
			link_rst_q <= link_rst_meta_q;
		end
	end

	// =========================================================
	// shift register
	// host holds serial_in stable around the edge, so it is sampled directly
	// relies on host setup
	assign shift_d = {shift_q[WIDTH-2:0], serial_in};

	always_ff @(posedge shift_clk or posedge link_rst_q) begin
		if (link_rst_q) begin
			shift_q <= {WIDTH{SR_RST_VAL}};
		end else begin
			shift_q <= shift_d;
		end
	end

	// toggles on every shift so the core sees motion even if the word repeats
	always_ff @(posedge shift_clk or posedge link_rst_q) begin
		if (link_rst_q) begin
			shift_tog_q <= SYNC_RST_VAL;
		end else begin
			shift_tog_q <= ~shift_tog_q;
		end
	end

	assign serial_out = shift_q[WIDTH-1];

	assign xfer.word = shift_q;
	assign xfer.shift_tog = shift_tog_q;

	// =========================================================
	// crossings into the core domain
	word_settle_sync #(.WIDTH(WIDTH)) u_word_sync (
		.clk(clk),
		.rst(sys_rst),
		.src(xfer),
		.word_out(settled_word)
	);

	level_sync u_strobe_sync (
		.clk(clk),
		.rst(sys_rst),
		.level_in(latch_strobe),
		.level_out(strobe_s)
	);

	level_sync u_blank_sync (
		.clk(clk),
		.rst(sys_rst),
		.level_in(out_blank),
		.level_out(blank_s)
	);

	// =========================================================
	// output latches
	// blanking has no path into this register or the shifter
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			latch_q <= {WIDTH{LATCH_RST_VAL}};
		end else if (strobe_s) begin
			latch_q <= settled_word;
		end
	end

	// =========================================================
	// output drivers
	// with strobe held high, blanking or fast continuous shifting (held back by the settle check) hides ripple during entry
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			drive_q <= {WIDTH{DRIVE_RST_VAL}};
		end else if (blank_s) begin
			drive_q <= {WIDTH{DRIVE_RST_VAL}};
		end else begin
			drive_q <= latch_q;
		end
	end

	assign drive_on = drive_q;

endmodule

// ===== driver_checker.sv
// checks on the driver ports
`timescale 1ns/10ps
module driver_checker #(
	parameter int WIDTH = 8
) (
	// clocks and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic shift_clk,
	// link and controls
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic latch_strobe,
	input wire logic out_blank,
	input wire logic [WIDTH-1:0] drive_on
);
	logic [3:0] cnt_q;
	logic [WIDTH-1:0] shadow_q;
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// mirror of the shifter; the first two link edges only release the link reset
	always_ff @(posedge shift_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 4'h0;
			shadow_q <= '0;
		end else begin
			if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
			if (cnt_q >= 4'h2) shadow_q <= {shadow_q[WIDTH-2:0], serial_in};
		end
	end
	sequence s_load;
		latch_strobe && !out_blank && $stable(shadow_q);
	endsequence
	// ====================
	// assertions; link edges never meet a core edge, so sampling here is race free
	a_chain_out: assert property (serial_out == shadow_q[WIDTH-1]) else $error("serial out off");
	a_link_start: assert property (cnt_q < 4'h3 |-> !serial_out && drive_on == '0) else $error("early shift");
	a_blank_off: assert property (out_blank[*4] |=> drive_on == '0) else $error("on while blanked");
	a_blank_quick: assert property ($rose(out_blank) |-> ##[1:4] drive_on == '0) else $error("blank slow");
	a_latch_hold: assert property ((!latch_strobe && !out_blank)[*6] |-> $stable(drive_on))
		else $error("moved without strobe");
	a_rise_enabled: assert property ((drive_on & ~$past(drive_on)) != '0
		|-> !($past(out_blank, 3) && $past(out_blank, 4))) else $error("rose while blanked");
	a_unblank_restore: assert property ((!latch_strobe && !out_blank)[*6] ##1
		(out_blank && !latch_strobe)[*7] ##1 (!latch_strobe && !out_blank)[*6]
		|-> drive_on == $past(drive_on, 14)) else $error("not restored");
	a_strobe_load: assert property (s_load[*8] ##1 s_load[*4] |-> drive_on == shadow_q)
		else $error("latch missed word");
	c_blank: cover property (out_blank[*4]);
	c_load: cover property (s_load[*8]);
	c_unblank: cover property ($fell(out_blank));
endmodule
bind serial_latched_driver driver_checker #(.WIDTH(WIDTH)) chk_u (.clk, .sys_rst, .shift_clk, .serial_in,
	.serial_out, .latch_strobe, .out_blank, .drive_on);

// ===== host_model.sv
// host model: gated link clock and serial data
`timescale 1ns/10ps
module host_model (
	// link to the driver
	output logic shift_clk,
	output logic serial_in
);
	initial {shift_clk, serial_in} = 2'b00;
	task automatic send(input logic [15:0] w, input int n);
		#3;
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = w[i];
			#6;
			shift_clk = 1'b1;
			#6;
			shift_clk = 1'b0;
		end
		// an idle line must not look like a held bit
		serial_in = ~serial_in;
	endtask
endmodule

// ===== tb.sv
// self-checking bench for the serial latched driver
`timescale 1ns/10ps
module tb;
	import driver_pkg::*;
	logic clk, sys_rst, shift_clk, serial_in, serial_out, latch_strobe, out_blank;
	logic [WORD_WIDTH-1:0] drive_on, w;
	int n_fail = 0;
	int checks_done = 0;
	host_model host_u (.shift_clk, .serial_in);
	serial_latched_driver dut_u (.clk, .sys_rst, .shift_clk, .serial_in, .serial_out, .latch_strobe, .out_blank,
		.drive_on);
	function automatic logic [WORD_WIDTH-1:0] want(input logic [WORD_WIDTH-1:0] v, input logic blank);
		return blank ? '0 : v;
	endfunction
	task automatic check(input logic [WORD_WIDTH-1:0] got, input logic [WORD_WIDTH-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic step(input logic s, input logic b, input int n);
		@(negedge clk);
		latch_strobe = s;
		out_blank = b;
		repeat (n) @(negedge clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#60000;
		n_fail++;
		give_verdict();
	end
	initial begin
		sys_rst = 1'b1;
		latch_strobe = 1'b0;
		out_blank = 1'b0;
		void'($urandom(32'h73885862));
		host_u.send(16'h0000, 2);
		step(1'b0, 1'b0, 16);
		sys_rst = 1'b0;
		for (int t = 0; t < 6; t++) begin
			w = t == 0 ? 8'hFF : t == 1 ? 8'h01 : 8'($urandom);
			host_u.send({8'h00, w}, 10);
			check_bit(serial_out, w[7]);
			step(1'b0, 1'b0, 8);
			step(1'b1, 1'b0, 3);
			step(1'b0, 1'b0, 8);
			check(drive_on, w);
			host_u.send({8'h00, ~w}, 8);
			check_bit(serial_out, ~w[7]);
			step(1'b0, 1'b1, 6);
			check(drive_on, want(w, 1'b1));
			step(1'b0, 1'b0, 6);
			check(drive_on, want(w, 1'b0));
			$display("test %0d done", t);
		end
		step(1'b1, 1'b0, 14);
		check(drive_on, ~w);
		w = 8'($urandom);
		step(1'b1, 1'b1, 0);
		host_u.send({8'h00, w}, 8);
		check_bit(serial_out, w[7]);
		step(1'b1, 1'b1, 14);
		check(drive_on, want(w, 1'b1));
		step(1'b1, 1'b0, 14);
		check(drive_on, want(w, 1'b0));
		$display("strobe held test done");
		give_verdict();
	end
endmodule
